// ==== verilog/tcpa_pkg.sv ====
// package: constants, register map and carrier types of the context packet assembler
package tcpa_pkg;
  localparam int NCTX   = 128;
  localparam int CTX_W  = 7;
  localparam int SLOT_W = 10;
  localparam int HIDX_W = 6;
  localparam int HLEN_W = 7;
  localparam int FPP_W  = 8;
  localparam int LEN_W  = 11;
  localparam int HA_W   = CTX_W + 1 + HIDX_W;

  localparam logic [HLEN_W-1:0] HDR_MAX    = 7'h40;
  localparam logic [HLEN_W-1:0] DESC_BYTES = 7'h02;
  localparam logic [HLEN_W-1:0] HLEN_RST   = 7'h02;
  localparam logic [FPP_W-1:0]  FPP_RST    = 8'h01;
  localparam logic [FPP_W-1:0]  RXDLY_RST  = 8'h04;

  // register byte offsets
  localparam logic [7:0] A_CFG   = 8'h00;
  localparam logic [7:0] A_SLOT  = 8'h04;
  localparam logic [7:0] A_HDR   = 8'h08;
  localparam logic [7:0] A_HLEN  = 8'h0c;
  localparam logic [7:0] A_RXDLY = 8'h10;

  // field positions
  localparam int CFG_CTX_LSB  = 0;
  localparam int CFG_LBL_LSB  = 8;
  localparam int CFG_FPP_LSB  = 16;
  localparam int CFG_EN_BIT   = 24;
  localparam int CFG_CMT_BIT  = 25;
  localparam int CFG_CS_BIT   = 26;
  localparam int CFG_BANK_BIT = 27;
  localparam int SLOT_LSB     = 0;
  localparam int SLOT_CTX_LSB = 10;
  localparam int SLOT_EN_BIT  = 17;
  localparam int HDR_IDX_LSB  = 0;
  localparam int HDR_CTX_LSB  = 6;
  localparam int HDR_DAT_LSB  = 16;
  localparam int HLEN_CTX_LSB = 0;
  localparam int HLEN_LSB     = 8;
  localparam int RXDLY_LSB    = 0;

  // descriptor layout
  localparam int DESC_CS_BIT  = 12;
  localparam int DESC_VER_LSB = 13;
  localparam int DESC_VER_W   = 3;
  localparam logic [DESC_VER_W-1:0] DESC_VER = 3'h0;

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int         HTRANS_ACT = 1;

  typedef struct packed {
    logic              valid;
    logic              frame_start;
    logic [SLOT_W-1:0] slot;
    logic [7:0]        data;
  } tcpa_tdm_type;

  typedef struct packed {
    logic              valid;
    logic              sop;
    logic [CTX_W-1:0]  ctx;
    logic [CTX_W-1:0]  context_label;
    logic [HLEN_W-1:0] hdr_len;
    logic [7:0]        data;
  } tcpa_pay_type;

  typedef struct packed {
    logic              valid;
    logic [CTX_W-1:0]  ctx;
    logic [HLEN_W-1:0] hdr_len;
    logic [LEN_W-1:0]  pkt_len;
  } tcpa_done_type;

  typedef struct packed {
    logic              req;
    logic [CTX_W-1:0]  ctx;
    logic [HIDX_W-1:0] idx;
  } tcpa_hreq_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } tcpa_hrsp_type;

  typedef struct packed {
    logic             valid;
    logic [CTX_W-1:0] context_label;
    logic             cs;
  } tcpa_rxpkt_type;

  typedef struct packed {
    logic             act;
    logic [CTX_W-1:0] act_ctx;
    logic             sw;
    logic [CTX_W-1:0] sw_ctx;
  } tcpa_rxevt_type;
endpackage

// ==== verilog/tcpa_ram.sv ====
// file: simple dual-port memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module tcpa_ram #(
  parameter int DW = 8,
  parameter int AW = 10
) (
  // clock
  input  wire logic          hclk,
  // write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  // read port
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // tcpa_ram
`default_nettype wire

// ==== verilog/tcpa_assembler.sv ====
// file: tdm context packet assembler with ahb-lite registers
//
// Contract
// R1: up to 128 contexts active at once
// R2: one packet stream per context, label carried
// R3: sync mode: any channels, any streams; code takes one tdm stream only
// R4: async mode: host keeps context to one stream
// R5: channel changes apply only at packet start
// R6: payload bytes in arrival order, stream inner
// R7: payload is whole frames in sequence
// R8: no partial frame; packet starts at frame
// R9: fixed header at most 64 bytes
// R10: host programs only static header fields
// R11: shadow header swaps in with new layout
// R12: host pads header to 64-byte minimum packet
// R13: reader starts at payload, stops at length
// R14: host keeps packets within 1518/1522 bytes
// R15: label 0-127, descriptor bits 7-11 zero
// R16: label is receive end assigned value
// R17: context-switch bit toggles on each change
// R18: descriptor version always zero
// R19: receive end switches on first changed packet
// R20: new context starts at next frame start
// R21: receive end waits programmed frames to activate
// R22: pending flag tells host to hold changes
// R23: switch bit and version positions fixed
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module tcpa_assembler (
  // clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // ahb-lite slave
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic      [31:0]             hrdata,
  output logic                         hresp,
  // tdm byte stream
  input  wire tcpa_pkg::tcpa_tdm_type  tdm_in,
  // payload and packet completion
  output tcpa_pkg::tcpa_pay_type       pay_out,
  output tcpa_pkg::tcpa_done_type      done_out,
  // header read port
  input  wire tcpa_pkg::tcpa_hreq_type hdr_req,
  output tcpa_pkg::tcpa_hrsp_type      hdr_rsp,
  // receive end
  input  wire tcpa_pkg::tcpa_rxpkt_type rx_pkt,
  output tcpa_pkg::tcpa_rxevt_type     rx_evt
);
  import tcpa_pkg::*;

  typedef struct packed {
    logic [NCTX-1:0]                   act;
    logic [NCTX-1:0]                   pend;
    logic [NCTX-1:0]                   stop;
    logic [NCTX-1:0]                   bank;
    logic [NCTX-1:0]                   cs;
    logic [NCTX-1:0]                   closing;
    logic [NCTX-1:0]                   rx_known;
    logic [NCTX-1:0]                   rx_cs;
    logic [NCTX-1:0][CTX_W-1:0]        lbl;
    logic [NCTX-1:0][CTX_W-1:0]        lbl_sh;
    logic [NCTX-1:0][FPP_W-1:0]        fpp;
    logic [NCTX-1:0][FPP_W-1:0]        fpp_sh;
    logic [NCTX-1:0][FPP_W-1:0]        fcnt;
    logic [NCTX-1:0][LEN_W-1:0]        bcnt;
    logic [NCTX-1:0][LEN_W-1:0]        clen;
    logic [NCTX-1:0][HLEN_W-1:0]       chl;
    logic [NCTX-1:0][1:0][HLEN_W-1:0]  hlen;
    logic [CTX_W-1:0]                  sel;
    logic [FPP_W-1:0]                  rxdly;
    logic [FPP_W-1:0]                  rxcnt;
    logic                              rxbusy;
    logic [CTX_W-1:0]                  rxctx;
    logic                              wr_pend;
    logic [7:0]                        waddr;
    logic [31:0]                       hrdata;
    tcpa_tdm_type                      tdm_d;
    logic                              hrd_v;
    logic [CTX_W-1:0]                  hrd_ctx;
    logic [HIDX_W-1:0]                 hrd_idx;
    tcpa_pay_type                      pay;
    tcpa_done_type                     done;
    tcpa_hrsp_type                     hrsp;
    tcpa_rxevt_type                    rxevt;
  } tcpa_st_type;

  tcpa_st_type r;
  tcpa_st_type n;

  // memory ports
  logic [7:0]        map0_q;
  logic [7:0]        map1_q;
  logic [7:0]        hdr_q;
  logic              wr_slot;
  logic              wr_hdr;
  logic [CTX_W-1:0]  ws_ctx;
  logic [CTX_W-1:0]  wh_ctx;
  logic [7:0]        map_wdata;
  logic [HA_W-1:0]   hdr_waddr;
  logic [HA_W-1:0]   hdr_raddr;

  assign wr_slot   = r.wr_pend && (r.waddr == A_SLOT);
  assign wr_hdr    = r.wr_pend && (r.waddr == A_HDR);
  assign ws_ctx    = hwdata[SLOT_CTX_LSB +: CTX_W];
  assign wh_ctx    = hwdata[HDR_CTX_LSB +: CTX_W];
  assign map_wdata = {hwdata[SLOT_EN_BIT], ws_ctx};
  // host writes only reach the shadow bank [R11]
  assign hdr_waddr = {wh_ctx, ~r.bank[wh_ctx], hwdata[HDR_IDX_LSB +: HIDX_W]};
  assign hdr_raddr = {hdr_req.ctx, r.bank[hdr_req.ctx], hdr_req.idx};

  // slot map, one bank per layout; any slot of the single tdm stream may join a context [R3]
  tcpa_ram #(.DW(8), .AW(SLOT_W)) u_map0 (
    .hclk  (hclk),
    .we    (wr_slot && r.bank[ws_ctx]),
    .waddr (hwdata[SLOT_LSB +: SLOT_W]),
    .wdata (map_wdata),
    .raddr (tdm_in.slot),
    .rdata (map0_q)
  );

  tcpa_ram #(.DW(8), .AW(SLOT_W)) u_map1 (
    .hclk  (hclk),
    .we    (wr_slot && !r.bank[ws_ctx]),
    .waddr (hwdata[SLOT_LSB +: SLOT_W]),
    .wdata (map_wdata),
    .raddr (tdm_in.slot),
    .rdata (map1_q)
  );

  // static header bytes, active and shadow per context [R10]
  tcpa_ram #(.DW(8), .AW(HA_W)) u_hdr (
    .hclk  (hclk),
    .we    (wr_hdr),
    .waddr (hdr_waddr),
    .wdata (hwdata[HDR_DAT_LSB +: 8]),
    .raddr (hdr_raddr),
    .rdata (hdr_q)
  );

  always_comb begin
    logic              fin;
    logic              bnd;
    logic [FPP_W:0]    fnext;
    logic [FPP_W:0]    feff;
    logic [CTX_W-1:0]  c;
    logic              hit0;
    logic              hit1;
    logic              found;
    logic [15:0]       desc;
    logic [HLEN_W-1:0] hl;
    logic [HLEN_W-1:0] wl;
    fin   = 1'b0;
    bnd   = 1'b0;
    fnext = '0;
    feff  = '0;
    c     = '0;
    hit0  = 1'b0;
    hit1  = 1'b0;
    found = 1'b0;
    desc  = '0;
    hl    = '0;
    wl    = '0;
    n     = r;

    // bus: address phase
    n.wr_pend = 1'b0;
    if (hsel && hready && htrans[HTRANS_ACT] && (hsize == HSIZE_WORD)) begin
      n.waddr   = haddr[7:0];
      n.wr_pend = hwrite;
      n.hrdata  = '0;
      if (!hwrite && (haddr[7:0] == A_CFG)) begin
        n.hrdata[CFG_CTX_LSB +: CTX_W]  = r.sel;
        n.hrdata[CFG_LBL_LSB +: CTX_W]  = r.lbl[r.sel];
        n.hrdata[CFG_FPP_LSB +: FPP_W]  = r.fpp[r.sel];
        n.hrdata[CFG_EN_BIT]            = r.act[r.sel];
        n.hrdata[CFG_CMT_BIT]           = r.pend[r.sel]; // [R22]
        n.hrdata[CFG_CS_BIT]            = r.cs[r.sel];
        n.hrdata[CFG_BANK_BIT]          = r.bank[r.sel];
      end else if (!hwrite && (haddr[7:0] == A_RXDLY)) begin
        n.hrdata[RXDLY_LSB +: FPP_W] = r.rxdly;
      end
    end

    // bus: data phase writes
    if (r.wr_pend && (r.waddr == A_CFG)) begin
      c        = hwdata[CFG_CTX_LSB +: CTX_W];
      n.sel    = c;
      if (!(hwdata[CFG_EN_BIT] && hwdata[CFG_CMT_BIT] && r.pend[c])) begin // [R22]
        n.lbl_sh[c] = hwdata[CFG_LBL_LSB +: CTX_W]; // label 0-127 by width [R15]
        n.fpp_sh[c] = hwdata[CFG_FPP_LSB +: FPP_W];
      end
      if (!hwdata[CFG_EN_BIT]) begin
        n.stop[c]     = 1'b1;
        n.pend[c]     = 1'b0;
        n.rx_known[c] = 1'b0;
      end else if (hwdata[CFG_CMT_BIT] && !r.pend[c]) begin
        n.pend[c] = 1'b1; // [R22]
        n.stop[c] = 1'b0;
      end
    end
    if (r.wr_pend && (r.waddr == A_HLEN)) begin
      c  = hwdata[HLEN_CTX_LSB +: CTX_W];
      wl = hwdata[HLEN_LSB +: HLEN_W];
      n.hlen[c][~r.bank[c]] = (wl > HDR_MAX) ? HDR_MAX : wl; // [R9]
    end
    if (r.wr_pend && (r.waddr == A_RXDLY)) begin
      n.rxdly = hwdata[RXDLY_LSB +: FPP_W];
    end

    // packet completion, one context per cycle
    n.done.valid = 1'b0;
    for (int i = 0; i < NCTX; i++) begin
      if (r.closing[i] && !found) begin
        found           = 1'b1;
        n.closing[i]    = 1'b0;
        n.done.valid    = 1'b1;
        n.done.ctx      = CTX_W'(i);
        hl              = r.chl[i];
        n.done.hdr_len  = hl; // payload pointer [R13]
        n.done.pkt_len  = r.clen[i] + LEN_W'(hl); // [R13]
      end
    end

    // tdm pipeline: stage 0 looks up the slot map
    n.tdm_d = tdm_in;
    // frame boundary for every context at once [R1]
    if (r.tdm_d.valid && r.tdm_d.frame_start) begin
      for (int i = 0; i < NCTX; i++) begin
        fnext = {1'b0, r.fcnt[i]} + 1'b1;
        feff  = (r.fpp[i] == '0) ? (FPP_W + 1)'(1) : {1'b0, r.fpp[i]};
        fin   = r.act[i] && (fnext >= feff); // whole frames only [R7] [R8]
        bnd   = !r.act[i] || fin; // changes wait for a packet start [R5]
        if (r.act[i]) begin
          n.fcnt[i] = fnext[FPP_W-1:0];
        end
        if (fin) begin
          n.closing[i] = 1'b1;
          n.clen[i]    = r.bcnt[i];
          n.chl[i]     = r.hlen[i][r.bank[i]]; // header of the closing packet [R13]
          n.bcnt[i]    = '0;
          n.fcnt[i]    = '0;
        end
        if (bnd && r.stop[i]) begin
          n.act[i]  = 1'b0;
          n.stop[i] = 1'b0;
        end else if (bnd && r.pend[i]) begin
          n.bank[i] = ~r.bank[i]; // shadow layout and header go live [R11]
          n.lbl[i]  = r.lbl_sh[i]; // [R2]
          n.fpp[i]  = r.fpp_sh[i];
          n.cs[i]   = r.cs[i] ^ r.act[i]; // [R17]
          n.act[i]  = 1'b1; // [R20]
          n.pend[i] = 1'b0; // [R22]
          n.bcnt[i] = '0;
          n.fcnt[i] = '0;
        end
      end
    end

    // stage 1: bytes in arrival order, after any swap of this frame [R6]
    n.pay.valid = 1'b0;
    hit0 = r.tdm_d.valid && map0_q[CTX_W] && n.act[map0_q[CTX_W-1:0]]
           && !n.bank[map0_q[CTX_W-1:0]];
    hit1 = r.tdm_d.valid && map1_q[CTX_W] && n.act[map1_q[CTX_W-1:0]]
           && n.bank[map1_q[CTX_W-1:0]];
    if (hit0 || hit1) begin
      c                   = hit0 ? map0_q[CTX_W-1:0] : map1_q[CTX_W-1:0];
      n.pay.valid         = 1'b1;
      n.pay.sop           = (n.bcnt[c] == '0); // [R8]
      n.pay.ctx           = c;
      n.pay.context_label = n.lbl[c]; // [R2]
      n.pay.hdr_len       = n.hlen[c][n.bank[c]];
      n.pay.data          = r.tdm_d.data;
      n.bcnt[c]           = n.bcnt[c] + 1'b1;
    end

    // header read: stage 1 memory, stage 2 descriptor overlay
    n.hrd_v   = hdr_req.req;
    n.hrd_ctx = hdr_req.ctx;
    n.hrd_idx = hdr_req.idx;
    desc[CTX_W-1:0]                    = r.lbl[r.hrd_ctx]; // bits 7-11 stay zero [R15]
    desc[DESC_CS_BIT]                  = r.cs[r.hrd_ctx]; // [R23]
    desc[DESC_VER_LSB +: DESC_VER_W]   = DESC_VER; // [R18] [R23]
    hl = r.hlen[r.hrd_ctx][r.bank[r.hrd_ctx]];
    n.hrsp.valid = r.hrd_v;
    if ({1'b0, r.hrd_idx} == hl - DESC_BYTES) begin
      n.hrsp.data = desc[15:8];
    end else if ({1'b0, r.hrd_idx} == hl - 1'b1) begin
      n.hrsp.data = desc[7:0];
    end else begin
      n.hrsp.data = hdr_q;
    end

    // receive end: first packet arms activation, switch bit flips config
    n.rxevt.act = 1'b0;
    n.rxevt.sw  = 1'b0;
    if (r.rxbusy) begin
      if (r.rxcnt == '0) begin
        n.rxevt.act     = 1'b1; // [R21]
        n.rxevt.act_ctx = r.rxctx;
        n.rxbusy        = 1'b0;
      end else if (r.tdm_d.valid && r.tdm_d.frame_start) begin
        n.rxcnt = r.rxcnt - 1'b1; // [R21]
      end
    end
    if (rx_pkt.valid) begin
      c = rx_pkt.context_label;
      if (!r.rx_known[c]) begin
        if (!r.rxbusy) begin
          n.rx_known[c] = 1'b1;
          n.rx_cs[c]    = rx_pkt.cs;
          n.rxbusy      = 1'b1;
          n.rxcnt       = r.rxdly; // [R21]
          n.rxctx       = c;
        end
      end else if (rx_pkt.cs != r.rx_cs[c]) begin
        n.rx_cs[c]     = rx_pkt.cs;
        n.rxevt.sw     = 1'b1; // [R19]
        n.rxevt.sw_ctx = c;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      for (int i = 0; i < NCTX; i++) begin
        r.fpp[i]     <= FPP_RST;
        r.fpp_sh[i]  <= FPP_RST;
        r.hlen[i][0] <= HLEN_RST;
        r.hlen[i][1] <= HLEN_RST;
      end
      r.rxdly <= RXDLY_RST;
    end else begin
      r <= n;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = r.hrdata;
  assign pay_out   = r.pay;
  assign done_out  = r.done;
  assign hdr_rsp   = r.hrsp;
  assign rx_evt    = r.rxevt;
endmodule // tcpa_assembler
`default_nettype wire

// ==== dv/tcpa_checker.sv ====
// checker: port-level timing relations of the context packet assembler
`timescale 1ns/10ps
`default_nettype none
module tcpa_checker
  import tcpa_pkg::*;
(
  // clock and reset
  input wire logic           hclk,
  input wire logic           hresetn,
  // streams
  input wire tcpa_tdm_type   tdm_in,
  input wire tcpa_pay_type   pay_out,
  input wire tcpa_done_type  done_out,
  // header port
  input wire tcpa_hreq_type  hdr_req,
  input wire tcpa_hrsp_type  hdr_rsp,
  // receive end
  input wire tcpa_rxpkt_type rx_pkt,
  input wire tcpa_rxevt_type rx_evt
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // frame start delayed to payload timing; contexts already seen this frame
  logic [1:0]      fs_r;
  logic [NCTX-1:0] seen_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fs_r   <= 2'h0;
      seen_r <= '0;
    end else begin
      fs_r <= {fs_r[0], tdm_in.valid && tdm_in.frame_start};
      for (int i = 0; i < NCTX; i++) begin
        seen_r[i] <= (seen_r[i] && !fs_r[1]) || (pay_out.valid && pay_out.ctx == CTX_W'(i));
      end
    end
  end

  chk_pay_cause: assert property (pay_out.valid |-> $past(tdm_in.valid, 2))
    else $error("payload byte without tdm byte");
  chk_pay_data: assert property (pay_out.valid |-> pay_out.data == $past(tdm_in.data, 2))
    else $error("payload byte differs from tdm byte");
  chk_sop_frame: assert property (pay_out.valid && pay_out.sop |->
    fs_r[1] || !seen_r[pay_out.ctx])
    else $error("packet start off frame start");
  chk_pay_hlen: assert property (pay_out.valid |-> pay_out.hdr_len <= HDR_MAX)
    else $error("header longer than limit");
  chk_hdr_lat: assert property (hdr_req.req |-> ##2 hdr_rsp.valid)
    else $error("header byte not answered");
  chk_done_ptr: assert property (done_out.valid |-> done_out.hdr_len <= HDR_MAX &&
    done_out.pkt_len >= LEN_W'(done_out.hdr_len))
    else $error("payload pointer beyond packet");
  chk_sw_cause: assert property (rx_evt.sw |-> $past(rx_pkt.valid) &&
    $past(rx_pkt.context_label) == rx_evt.sw_ctx)
    else $error("switch without matching packet");
  chk_act_pulse: assert property (rx_evt.act |=> !rx_evt.act)
    else $error("activation not a pulse");
endmodule // tcpa_checker

bind tcpa_assembler tcpa_checker chk_u (.hclk(hclk), .hresetn(hresetn), .tdm_in(tdm_in),
  .pay_out(pay_out), .done_out(done_out), .hdr_req(hdr_req), .hdr_rsp(hdr_rsp),
  .rx_pkt(rx_pkt), .rx_evt(rx_evt));
`default_nettype wire

// ==== dv/tcpa_tdm_src.sv ====
// partner: single-stream tdm frame source, 8 slots per frame
`timescale 1ns/10ps
`default_nettype none
module tcpa_tdm_src
  import tcpa_pkg::*;
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // control
  input  wire logic       run,
  // tdm stream
  output var tcpa_tdm_type tdm_in
);
  localparam int NSLOT = 8;
  localparam int LAST  = 9;
  logic [3:0] cnt;
  logic [3:0] fr;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt    <= 4'h0;
      fr     <= 4'h0;
      tdm_in <= '0;
    end else begin
      tdm_in.frame_start <= 1'b0;
      if (cnt == 4'h0 && !run) begin
        // idle: frames only start whole, data line keeps toggling
        fr           <= 4'h0;
        tdm_in.valid <= 1'b0;
        tdm_in.data  <= ~tdm_in.data;
      end else begin
        cnt <= (cnt == LAST) ? 4'h0 : cnt + 4'h1;
        if (cnt == LAST) fr <= fr + 4'h1;
        tdm_in.valid       <= (cnt < NSLOT);
        tdm_in.frame_start <= (cnt == 4'h0);
        tdm_in.slot        <= SLOT_W'(cnt);
        tdm_in.data        <= (cnt < NSLOT) ? {fr, cnt} : ~tdm_in.data;
      end
    end
  end
endmodule // tcpa_tdm_src
`default_nettype wire

// ==== dv/tb_top.sv ====
// testbench: registers, context setup and modification, receive end, reset
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import tcpa_pkg::*;
  localparam logic [7:0]  T_A [4] = '{A_RXDLY, 8'h20, 8'h14, A_RXDLY};
  localparam logic [31:0] T_W [4] = '{32'hffff_ffa5, 32'hffff_ffff, 32'h1234_5678, 32'h1};
  localparam logic [31:0] T_E [4] = '{32'ha5, 32'h0, 32'h0, 32'h1};
  logic           hclk = 1'b0;
  logic           hresetn = 1'b0;
  logic           hsel = 1'b0;
  logic           hwrite = 1'b0;
  logic           run = 1'b0;
  logic [31:0]    haddr = '0;
  logic [31:0]    hwdata = '0;
  logic [31:0]    q;
  logic [1:0]     htrans = '0;
  logic [2:0]     hsize = '0;
  logic           hreadyout;
  logic           hresp;
  logic [31:0]    hrdata;
  tcpa_tdm_type   tdm_in;
  tcpa_pay_type   pay_out;
  tcpa_done_type  done_out;
  tcpa_hreq_type  hdr_req = '0;
  tcpa_hrsp_type  hdr_rsp;
  tcpa_rxpkt_type rx_pkt = '0;
  tcpa_rxevt_type rx_evt;
  int             miscompares = 0;
  int             n_compared = 0;
  int             act_n = 0;
  int             sw_n = 0;
  logic [6:0]     act_c;
  logic [6:0]     sw_c;
  logic [15:0]    e;
  logic [15:0]    pay_q [$];
  tcpa_done_type  done_q [$];

  always #2.5 hclk = ~hclk;

  tcpa_tdm_src src_u (.hclk(hclk), .hresetn(hresetn), .run(run), .tdm_in(tdm_in));
  tcpa_assembler dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tdm_in(tdm_in),
    .pay_out(pay_out), .done_out(done_out), .hdr_req(hdr_req), .hdr_rsp(hdr_rsp),
    .rx_pkt(rx_pkt), .rx_evt(rx_evt));

  // output monitor
  always @(posedge hclk) begin
    if (pay_out.valid === 1'b1) pay_q.push_back({pay_out.sop, pay_out.context_label,
      pay_out.data});
    if (done_out.valid === 1'b1) done_q.push_back(done_out);
    if (rx_evt.act === 1'b1) begin
      act_n++;
      act_c = rx_evt.act_ctx;
    end
    if (rx_evt.sw === 1'b1) begin
      sw_n++;
      sw_c = rx_evt.sw_ctx;
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    hsize  <= HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask

  task automatic rxp(input logic [6:0] l, input logic c);
    rx_pkt <= '{1'b1, l, c};
    @(posedge hclk);
    rx_pkt <= '0;
    cyc(2);
  endtask

  task automatic hdr_chk(input logic [5:0] i, input logic [7:0] x);
    hdr_req <= '{1'b1, 7'd3, i};
    @(posedge hclk);
    hdr_req <= '0;
    cyc(2);
    `CHK(hdr_rsp, tcpa_hrsp_type'({1'b1, x}))
  endtask

  task automatic final_report();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #20000;
    miscompares++;
    final_report();
  end

  initial begin
    cyc(12);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, T_A[i], T_W[i]);
      rd_chk(T_A[i], T_E[i]);
    end
    rxp(7'h05, 1'b0);
    cyc(20);
    `CHK(act_n, 0)
    // first setup: empty map, short header
    for (int s = 0; s < 8; s++) bus(1'b1, A_SLOT, 32'(3 << 10 | s));
    bus(1'b1, A_HLEN, 32'h0000_0403);
    bus(1'b1, A_CFG, 32'h0301_2a03);
    rd_chk(A_CFG, 32'h0201_0003);
    run <= 1'b1;
    cyc(25);
    run <= 1'b0;
    cyc(20);
    rd_chk(A_CFG, 32'h0901_2a03);
    `CHK(act_n, 1)
    `CHK(act_c, 7'h05)
    rxp(7'h05, 1'b0);
    rxp(7'h05, 1'b1);
    `CHK(sw_n, 1)
    `CHK(sw_c, 7'h05)
    // modification: slots 2 and 5, two frames, 64-byte header
    for (int s = 0; s < 8; s++) bus(1'b1, A_SLOT, 32'((s == 2 || s == 5) << 17 | 3 << 10 | s));
    bus(1'b1, A_HLEN, 32'h0000_4603);
    bus(1'b1, A_HDR, 32'h00c5_00c0);
    bus(1'b1, A_CFG, 32'h0302_2b03);
    bus(1'b1, A_CFG, 32'h0301_1103);
    rd_chk(A_CFG, 32'h0b01_2a03);
    pay_q.delete();
    done_q.delete();
    run <= 1'b1;
    cyc(45);
    run <= 1'b0;
    cyc(20);
    `CHK(pay_q.size(), 10)
    for (int k = 0; k < 10; k++) begin
      e = {(k % 4 == 0), 7'h2b, 4'(k / 2), ((k % 2) ? 4'h5 : 4'h2)};
      `CHK(pay_q[k], e)
    end
    `CHK(done_q.size(), 3)
    `CHK(done_q[0], tcpa_done_type'({1'b1, 7'd3, 7'h04, 11'h004}))
    for (int j = 1; j < 3; j++) `CHK(done_q[j], tcpa_done_type'({1'b1, 7'd3, 7'h40, 11'h044}))
    rd_chk(A_CFG, 32'h0502_2b03);
    hdr_chk(6'd62, 8'h10);
    hdr_chk(6'd63, 8'h2b);
    hdr_chk(6'd0, 8'hc5);
    // teardown waits for the packet boundary
    bus(1'b1, A_CFG, 32'h0000_0003);
    run <= 1'b1;
    cyc(15);
    run <= 1'b0;
    cyc(20);
    rd_chk(A_CFG, 32'h0402_2b03);
    // second reset with the source idle
    hresetn <= 1'b0;
    cyc(2);
    `CHK(pay_out, '0)
    `CHK(hreadyout, 1'b1)
    `CHK(hresp, 1'b0)
    hresetn <= 1'b1;
    rd_chk(A_RXDLY, 32'h4);
    rd_chk(A_CFG, 32'h0001_0000);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
